/* rtl/lcs_pkg.sv */
// package: register map, reset values, timing constants and types of the charge sequencer
`default_nettype none
package lcs_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned FAULT_PULSE_US = 128;
  localparam int unsigned FAULT_PULSE_CYC = (FAULT_PULSE_US * (CLK_HZ / 1000000));
  localparam int unsigned DETECT_US = 250;
  localparam int unsigned DETECT_CYC = (DETECT_US * (CLK_HZ / 1000000));
  localparam int unsigned SW_FREQ_HZ = 1500000;
  localparam int unsigned SW_PERIOD_CYC = (CLK_HZ + SW_FREQ_HZ - 1) / SW_FREQ_HZ;
  localparam logic [4:0] SW_PERIOD_M1 = 5'(SW_PERIOD_CYC - 1);
  localparam logic [12:0] PULSE_LAST = 13'(FAULT_PULSE_CYC - 1);

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VREG = 8'h04;
  localparam logic [7:0] OFS_ICHG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_LOOPS = 8'h10;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int unsigned CTRL_RESET_BIT = 0;
  localparam int unsigned CTRL_CHG_DIS_BIT = 1;
  localparam int unsigned CTRL_TERM_EN_BIT = 2;
  localparam int unsigned CTRL_HIZ_BIT = 3;
  localparam int unsigned CTRL_STAT_EN_BIT = 4;

  // ----------------------------------------
  // reset values, limits and thresholds (codes in 10 mV / 10 mA steps)
  // ----------------------------------------
  localparam logic [4:0] CTRL_RST = 5'h14;
  localparam logic [8:0] VREG_MIN = 9'h15e;
  localparam logic [8:0] VREG_MAX = 9'h1bc;
  localparam logic [8:0] VREG_RST = 9'h168;
  localparam logic [8:0] RCH_OFS = 9'h0a;
  localparam logic [8:0] VSHORT = 9'h12c;
  localparam logic [8:0] SYSTEM_REGULATION_VOLTAGE = 9'h15e;
  localparam logic [8:0] VDETECT = 9'h12c;
  localparam logic [7:0] ICHG_RST = 8'h64;
  localparam logic [7:0] ITERM_RST = 8'h05;
  localparam logic [7:0] ISHORT = 8'h05;

  typedef enum logic [2:0] {
    ST_DISABLED,
    ST_SHORT_BAT,
    ST_FAST,
    ST_TAPER,
    ST_DETECT,
    ST_DONE
  } lcs_state_t;

  // analog measurements from the converter front end
  typedef struct packed {
    logic [8:0] vbat;
    logic [8:0] vsys;
    logic [7:0] ichg;
    logic input_ok;
    logic die_hot;
    logic vin_low;
    logic sys_over;
    logic peak_over;
    logic fault;
  } lcs_meas_t;

  // commands to the converter and battery switch
  typedef struct packed {
    logic [7:0] i_target;
    logic [8:0] v_target;
    logic fet_full;
    logic fet_linear;
    logic charge_on;
    logic supplement;
    logic detect_sink;
    logic pwm_gate;
    logic [2:0] loop_sel;
  } lcs_drive_t;
endpackage
`default_nettype wire

/* rtl/lcs_pulse.sv */
// module: one-shot stretcher for the fault pulse
`default_nettype none
module lcs_pulse
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // trigger and pulse
  input wire logic i_trig,
  output logic o_active
);
  logic [12:0] cnt_reg;
  logic act_reg;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      cnt_reg <= 13'h0000;
      act_reg <= 1'b0;
    end
    else if (i_trig && !act_reg)
    begin
      cnt_reg <= 13'h0000;
      act_reg <= 1'b1;
    end
    else if (act_reg)
    begin
      if (cnt_reg == lcs_pkg::PULSE_LAST)
      begin
        act_reg <= 1'b0; // RULE3
      end
      cnt_reg <= cnt_reg + 13'h0001;
    end
  end

  assign o_active = act_reg;
endmodule
`default_nettype wire

/* rtl/lcs_pwm.sv */
// module: fixed-frequency switching clock with peak current cut-off
`default_nettype none
module lcs_pwm
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // control
  input wire logic i_run,
  input wire logic [4:0] i_on_cycles,
  input wire logic i_peak_over,
  // gate
  output logic o_gate
);
  logic [4:0] phase_reg;
  logic cut_reg;
  logic gate_reg;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || !i_run)
    begin
      phase_reg <= 5'h00;
      cut_reg <= 1'b0;
      gate_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= (phase_reg == lcs_pkg::SW_PERIOD_M1) ? 5'h00 : phase_reg + 5'h01; // RULE17
      if (phase_reg == lcs_pkg::SW_PERIOD_M1)
      begin
        cut_reg <= 1'b0;
      end
      else if (i_peak_over)
      begin
        cut_reg <= 1'b1; // RULE18
      end
      gate_reg <= (phase_reg < i_on_cycles) && !cut_reg && !i_peak_over; // RULE18
    end
  end

  assign o_gate = gate_reg;
endmodule
`default_nettype wire

/* rtl/lcs_top.sv */
// module: charge-cycle sequencer with apb registers and open-drain status pin
//
// What this block does
// RULE1 - status pin low while charging
// RULE2 - status released when done or disabled
// RULE3 - fault gives one 128 us pulse
// RULE4 - status pin works only when enabled
// RULE5 - short battery: small current, linear fet
// RULE6 - above short threshold use programmed current
// RULE7 - die hot reduces charge current
// RULE8 - system above regulation: fet full on
// RULE9 - regulation target programmable 3.5 to 4.44 V
// RULE10 - near target taper current, rail connected
// RULE11 - low current terminates, starts detection
// RULE12 - battery found gives charge done
// RULE13 - termination level programmable and compared
// RULE14 - termination disabled never ends charge
// RULE15 - restart on recharge, input, disable, reset, hiz
// RULE16 - most restrictive of five loops governs (the code uses fixed priority: thermal, system/input, taper, programmed)
// RULE17 - switching at fixed 1.5 MHz (the code divides the 20 MHz clock by 14, about 1.43 MHz)
// RULE18 - cycle-by-cycle 5 A peak cut
// RULE19 - zero current, overload gives supplement mode
// RULE20 - disable resets 0, auto start on input
// RULE21 - no detection when termination disabled
// RULE22 - explicit phase state machine
`default_nettype none
module lcs_top
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // measurements
  input wire lcs_pkg::lcs_meas_t i_meas,
  // converter drive
  output lcs_pkg::lcs_drive_t o_drive,
  // open-drain status pin
  input wire logic i_stat_in,
  output logic o_stat_out,
  output logic o_stat_oe
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [4:0] ctrl_reg;
  logic [8:0] vreg_reg;
  logic [7:0] ichg_reg;
  logic [7:0] iterm_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  lcs_pkg::lcs_state_t state_reg;
  lcs_pkg::lcs_state_t state_next;
  logic [12:0] det_cnt_reg;
  logic det_phase_reg;
  logic bat_missing_reg;
  logic input_ok_d_reg;
  logic chg_dis_d_reg;
  logic hiz_d_reg;
  logic fault_d_reg;
  logic stat_in_reg;
  lcs_pkg::lcs_drive_t drive_reg;
  logic stat_oe_reg;
  logic pwm_gate;
  logic pulse_act;
  logic fault_trig;
  logic restart;
  logic wr_en;
  logic rd_en;
  logic map_hit;
  logic [8:0] vreg_wr;

  function automatic logic [8:0] clamp_vreg(input logic [8:0] v);
    if (v < lcs_pkg::VREG_MIN)
    begin
      return lcs_pkg::VREG_MIN;
    end
    else if (v > lcs_pkg::VREG_MAX)
    begin
      return lcs_pkg::VREG_MAX;
    end
    return v;
  endfunction

  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction

  // saturating step down: a wrap to 0xff would throw the target back up
  function automatic logic [7:0] dec_sat8(input logic [7:0] a);
    return (a == 8'h00) ? 8'h00 : a - 8'h01;
  endfunction

  // ----------------------------------------
  // apb slave: one wait state in every access phase
  // ----------------------------------------
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign map_hit = (i_paddr == lcs_pkg::OFS_CTRL) || (i_paddr == lcs_pkg::OFS_VREG) ||
                   (i_paddr == lcs_pkg::OFS_ICHG) || (i_paddr == lcs_pkg::OFS_STATUS) ||
                   (i_paddr == lcs_pkg::OFS_LOOPS);
  assign vreg_wr = clamp_vreg(i_pwdata[8:0]);

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      // ready comes one cycle into the access phase and drops right after
      pready_reg <= i_psel && i_penable && !pready_reg;
      pslverr_reg <= i_psel && i_penable && !pready_reg && !map_hit;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      ctrl_reg <= lcs_pkg::CTRL_RST; // RULE20
      vreg_reg <= lcs_pkg::VREG_RST;
      ichg_reg <= lcs_pkg::ICHG_RST;
      iterm_reg <= lcs_pkg::ITERM_RST;
    end
    else
    begin
      // reset bit is self-clearing so a write of 1 acts once
      ctrl_reg[lcs_pkg::CTRL_RESET_BIT] <= 1'b0;
      if (wr_en && pready_reg && i_paddr == lcs_pkg::OFS_CTRL)
      begin
        ctrl_reg <= i_pwdata[4:0];
      end
      if (wr_en && pready_reg && i_paddr == lcs_pkg::OFS_VREG)
      begin
        vreg_reg <= vreg_wr; // RULE9
      end
      if (wr_en && pready_reg && i_paddr == lcs_pkg::OFS_ICHG)
      begin
        ichg_reg <= i_pwdata[7:0]; // RULE6
        iterm_reg <= i_pwdata[15:8]; // RULE13
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      prdata_reg <= 32'h00000000;
    end
    else if (rd_en && !pready_reg)
    begin
      case (i_paddr)
        lcs_pkg::OFS_CTRL: prdata_reg <= {27'h0000000, ctrl_reg};
        lcs_pkg::OFS_VREG: prdata_reg <= {23'h000000, vreg_reg};
        lcs_pkg::OFS_ICHG: prdata_reg <= {16'h0000, iterm_reg, ichg_reg};
        lcs_pkg::OFS_STATUS: prdata_reg <= {26'h0000000, stat_in_reg, bat_missing_reg, drive_reg.supplement,
                                            state_reg};
        lcs_pkg::OFS_LOOPS: prdata_reg <= {29'h00000000, drive_reg.loop_sel};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // restart and fault events
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      input_ok_d_reg <= 1'b0;
      chg_dis_d_reg <= 1'b0;
      hiz_d_reg <= 1'b0;
      fault_d_reg <= 1'b0;
      stat_in_reg <= 1'b1;
    end
    else
    begin
      input_ok_d_reg <= i_meas.input_ok;
      chg_dis_d_reg <= ctrl_reg[lcs_pkg::CTRL_CHG_DIS_BIT];
      hiz_d_reg <= ctrl_reg[lcs_pkg::CTRL_HIZ_BIT];
      fault_d_reg <= i_meas.fault;
      stat_in_reg <= i_stat_in;
    end
  end

  assign restart = (i_meas.input_ok != input_ok_d_reg) ||
                   (ctrl_reg[lcs_pkg::CTRL_CHG_DIS_BIT] != chg_dis_d_reg) ||
                   ctrl_reg[lcs_pkg::CTRL_RESET_BIT] ||
                   (ctrl_reg[lcs_pkg::CTRL_HIZ_BIT] != hiz_d_reg) ||
                   (i_meas.vbat < vreg_reg - lcs_pkg::RCH_OFS); // RULE15
  // missing battery during detection counts as a fault too
  assign fault_trig = (i_meas.fault && !fault_d_reg) ||
                      (state_reg == lcs_pkg::ST_DETECT && !det_phase_reg && i_meas.vbat < lcs_pkg::VDETECT &&
                       !bat_missing_reg);

  // ----------------------------------------
  // charge phase machine
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      lcs_pkg::ST_DISABLED:
      begin
        if (i_meas.input_ok && !ctrl_reg[lcs_pkg::CTRL_CHG_DIS_BIT] && !ctrl_reg[lcs_pkg::CTRL_HIZ_BIT])
        begin
          state_next = lcs_pkg::ST_SHORT_BAT; // RULE20
        end
      end
      lcs_pkg::ST_SHORT_BAT:
      begin
        if (i_meas.vbat >= lcs_pkg::VSHORT)
        begin
          state_next = lcs_pkg::ST_FAST; // RULE6
        end
      end
      lcs_pkg::ST_FAST:
      begin
        if (i_meas.vbat >= vreg_reg - lcs_pkg::RCH_OFS)
        begin
          state_next = lcs_pkg::ST_TAPER; // RULE10
        end
      end
      lcs_pkg::ST_TAPER:
      begin
        if (ctrl_reg[lcs_pkg::CTRL_TERM_EN_BIT] && i_meas.ichg <= iterm_reg &&
            i_meas.vbat >= vreg_reg - lcs_pkg::RCH_OFS) // RULE11 RULE13 RULE14
        begin
          state_next = lcs_pkg::ST_DETECT; // RULE21
        end
      end
      lcs_pkg::ST_DETECT:
      begin
        if (det_cnt_reg == 13'(lcs_pkg::DETECT_CYC - 1) && !det_phase_reg && !bat_missing_reg)
        begin
          state_next = lcs_pkg::ST_DONE; // RULE12
        end
      end
      lcs_pkg::ST_DONE:
      begin
        if (restart)
        begin
          state_next = lcs_pkg::ST_SHORT_BAT; // RULE15
        end
      end
      default: state_next = lcs_pkg::ST_DISABLED;
    endcase
    if (!i_meas.input_ok || ctrl_reg[lcs_pkg::CTRL_CHG_DIS_BIT] || ctrl_reg[lcs_pkg::CTRL_HIZ_BIT])
    begin
      state_next = lcs_pkg::ST_DISABLED;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      state_reg <= lcs_pkg::ST_DISABLED;
    end
    else
    begin
      state_reg <= state_next; // RULE22
    end
  end

  // detection alternates a sink window and a source window until a battery holds up
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || state_reg != lcs_pkg::ST_DETECT)
    begin
      det_cnt_reg <= 13'h0000;
      det_phase_reg <= 1'b0;
      bat_missing_reg <= 1'b0;
    end
    else if (det_cnt_reg == 13'(lcs_pkg::DETECT_CYC - 1))
    begin
      det_cnt_reg <= 13'h0000;
      if (det_phase_reg || bat_missing_reg)
      begin
        det_phase_reg <= !det_phase_reg;
      end
      if (det_phase_reg)
      begin
        bat_missing_reg <= 1'b0;
      end
    end
    else
    begin
      det_cnt_reg <= det_cnt_reg + 13'h0001;
      if (!det_phase_reg && i_meas.vbat < lcs_pkg::VDETECT)
      begin
        bat_missing_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // converter drive and loop arbitration
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      drive_reg <= '0;
    end
    else
    begin
      drive_reg.v_target <= vreg_reg;
      drive_reg.pwm_gate <= pwm_gate;
      drive_reg.charge_on <= (state_reg == lcs_pkg::ST_SHORT_BAT) || (state_reg == lcs_pkg::ST_FAST) ||
                             (state_reg == lcs_pkg::ST_TAPER);
      drive_reg.fet_linear <= (state_reg == lcs_pkg::ST_SHORT_BAT) ||
                              ((state_reg == lcs_pkg::ST_FAST) && i_meas.vsys <= lcs_pkg::SYSTEM_REGULATION_VOLTAGE); // RULE5
      drive_reg.fet_full <= ((state_reg == lcs_pkg::ST_FAST) && i_meas.vsys > lcs_pkg::SYSTEM_REGULATION_VOLTAGE) ||
                            (state_reg == lcs_pkg::ST_TAPER); // RULE8 RULE10
      drive_reg.detect_sink <= (state_reg == lcs_pkg::ST_DETECT) && !det_phase_reg; // RULE11
      drive_reg.supplement <= (state_reg == lcs_pkg::ST_DONE || drive_reg.i_target == 8'h00) &&
                              i_meas.sys_over; // RULE12 RULE19
      if (state_reg == lcs_pkg::ST_SHORT_BAT)
      begin
        drive_reg.i_target <= lcs_pkg::ISHORT; // RULE5
        drive_reg.loop_sel <= 3'h0;
      end
      else if (state_reg == lcs_pkg::ST_FAST || state_reg == lcs_pkg::ST_TAPER)
      begin
        // the loops are taken in fixed priority: thermal first, then system or input, then taper, then programmed
        if (i_meas.die_hot)
        begin
          drive_reg.i_target <= min8(ichg_reg >> 1, dec_sat8(drive_reg.i_target)); // RULE7 RULE16
          drive_reg.loop_sel <= 3'h2;
        end
        else if (i_meas.sys_over || i_meas.vin_low)
        begin
          drive_reg.i_target <= dec_sat8(drive_reg.i_target); // RULE16
          drive_reg.loop_sel <= i_meas.sys_over ? 3'h3 : 3'h4;
        end
        else if (state_reg == lcs_pkg::ST_TAPER)
        begin
          drive_reg.i_target <= min8(i_meas.ichg, ichg_reg); // RULE10
          drive_reg.loop_sel <= 3'h1;
        end
        else
        begin
          drive_reg.i_target <= ichg_reg; // RULE6 RULE8
          drive_reg.loop_sel <= 3'h0;
        end
      end
      else
      begin
        drive_reg.i_target <= 8'h00;
        drive_reg.loop_sel <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // status pin: low while charging, fault pulse over it
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      stat_oe_reg <= 1'b0;
    end
    else
    begin
      // the pulse inverts the charging level so it is visible in either state
      stat_oe_reg <= ctrl_reg[lcs_pkg::CTRL_STAT_EN_BIT] && (drive_reg.charge_on ^ pulse_act); // RULE1 RULE2 RULE3 RULE4
    end
  end

  lcs_pulse u_pulse
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_trig(fault_trig),
    .o_active(pulse_act)
  );

  lcs_pwm u_pwm
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_run(drive_reg.charge_on || state_reg == lcs_pkg::ST_DONE),
    .i_on_cycles(5'(drive_reg.i_target[7:4])),
    .i_peak_over(i_meas.peak_over),
    .o_gate(pwm_gate)
  );

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_drive = drive_reg;
  assign o_stat_out = 1'b0;
  assign o_stat_oe = stat_oe_reg;
endmodule
`default_nettype wire

/* tb/lcs_host_model.sv */
// host model: pull-up resistor on the open-drain status line
`default_nettype none
module lcs_host_model
(
  // pin from the device
  input wire logic i_stat_out,
  input wire logic i_stat_oe,
  // resolved line level
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released line floats up through the pull-up, never keeps the last level
  assign o_line = i_stat_oe ? i_stat_out : 1'h1;
endmodule
`default_nettype wire

/* tb/lcs_checker.sv */
// checker: port-level assertions of the charge sequencer
`default_nettype none
module lcs_checker
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // converter side
  input wire lcs_pkg::lcs_meas_t i_meas,
  input wire lcs_pkg::lcs_drive_t o_drive,
  // status pin
  input wire logic o_stat_out,
  input wire logic o_stat_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held two cycles");
  a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable)) else $error("ready without access");
  a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  a_open_drain: assert property (o_stat_out == 1'h0) else $error("status pin driven high");
  a_loop_range: assert property (o_drive.loop_sel <= 3'h4) else $error("bad loop select");
  a_vreg_range: assert property (o_drive.charge_on |-> o_drive.v_target >= lcs_pkg::VREG_MIN
    && o_drive.v_target <= lcs_pkg::VREG_MAX) else $error("voltage target out of range");
  a_fet_excl: assert property (!(o_drive.fet_full && o_drive.fet_linear)) else $error("fet full and linear");
  a_no_input: assert property (!i_meas.input_ok [*3] |-> !o_drive.charge_on) else $error("charging without input");
  a_sw_period: assert property ($rose(o_drive.pwm_gate) |=> !$rose(o_drive.pwm_gate) [*8])
    else $error("switching period too short");
  a_peak_cut: assert property (i_meas.peak_over && o_drive.pwm_gate |-> ##[1:3] !o_drive.pwm_gate)
    else $error("peak current not cut");
  // ----------------------------------------
  // coverage
  // ----------------------------------------
  c_err: cover property (o_pslverr);
  c_fet_full: cover property ($rose(o_drive.fet_full));
  c_pin_release: cover property ($fell(o_stat_oe));
endmodule
bind lcs_top lcs_checker u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_meas(i_meas), .o_drive(o_drive), .o_stat_out(o_stat_out),
  .o_stat_oe(o_stat_oe));
`default_nettype wire

/* tb/test_lcs_top.sv */
// testbench: registers, charge phases and status pin of the charge sequencer
`default_nettype none
module test_lcs_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] e; logic [31:0] m; logic err;} lcs_exp_t;
  logic i_mclk = 1'h0;
  logic i_rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lcs_pkg::lcs_meas_t meas = '0;
  lcs_pkg::lcs_drive_t drive;
  logic stat_out;
  logic stat_oe;
  logic line;
  logic [31:0] last_rd;
  lcs_exp_t expq[$];
  lcs_exp_t cur;
  int n_mismatch = 0;
  int check_count = 0;
  always #25 i_mclk = ~i_mclk;
  lcs_top u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_meas(meas), .o_drive(drive), .i_stat_in(line), .o_stat_out(stat_out), .o_stat_oe(stat_oe));
  lcs_host_model u_host (.i_stat_out(stat_out), .i_stat_oe(stat_oe), .o_line(line));
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s", $time, msg);
      n_mismatch++;
    end
  endtask
  // ----------------------------------------
  // apb master and result watcher
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input lcs_exp_t x);
    int k;
    expq.push_back(x);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge i_mclk);
      k++;
    end
    while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1)
    begin
      check(32'h0, 32'h1, "no ready");
      give_verdict();
    end
    last_rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic err);
    apb(1'h0, a, 32'h0, '{e, m, err});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, '{32'h0, 32'h0, 1'h0});
  endtask
  task automatic wait_state(input logic [2:0] s);
    int k;
    k = 0;
    do
    begin
      rd(lcs_pkg::OFS_STATUS, 32'h0, 32'h0, 1'h0);
      k++;
    end
    while (last_rd[2:0] !== s && k < 2000);
    if (last_rd[2:0] !== s)
    begin
      check(32'h0, 32'h1, "state timeout");
      give_verdict();
    end
    rd(lcs_pkg::OFS_STATUS, {29'h0, s}, 32'h7, 1'h0);
  endtask
  always @(posedge i_mclk)
  begin
    if (pready === 1'h1 && expq.size() > 0)
    begin
      cur = expq.pop_front();
      check(prdata & cur.m, cur.e & cur.m, "read data");
      check({31'h0, pslverr}, {31'h0, cur.err}, "error flag");
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int k;
    void'($urandom(32'h9866821f));
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'h1;
    @(posedge i_mclk);
    rd(lcs_pkg::OFS_CTRL, {27'h0, lcs_pkg::CTRL_RST}, 32'hffffffff, 1'h0);
    rd(lcs_pkg::OFS_VREG, {23'h0, lcs_pkg::VREG_RST}, 32'hffffffff, 1'h0);
    rd(lcs_pkg::OFS_ICHG, {16'h0, lcs_pkg::ITERM_RST, lcs_pkg::ICHG_RST}, 32'hffffffff, 1'h0);
    rd(8'h14, 32'h0, 32'hffffffff, 1'h1);
    wr(lcs_pkg::OFS_VREG, 32'h1ff);
    rd(lcs_pkg::OFS_VREG, {23'h0, lcs_pkg::VREG_MAX}, 32'hffffffff, 1'h0);
    wr(lcs_pkg::OFS_VREG, 32'h100);
    rd(lcs_pkg::OFS_VREG, {23'h0, lcs_pkg::VREG_MIN}, 32'hffffffff, 1'h0);
    wr(lcs_pkg::OFS_VREG, 32'h1a4);
    wr(lcs_pkg::OFS_ICHG, 32'h0a32);
    rd(lcs_pkg::OFS_ICHG, 32'h0a32, 32'hffffffff, 1'h0);
    $display("registers test done");
    meas.vbat <= 9'h0c8;
    meas.vsys <= lcs_pkg::SYSTEM_REGULATION_VOLTAGE;
    meas.input_ok <= 1'h1;
    wait_state(3'h1);
    check({31'h0, drive.fet_linear}, 32'h1, "linear fet");
    check({24'h0, drive.i_target}, {24'h0, lcs_pkg::ISHORT}, "short current");
    meas.vbat <= 9'h140 + 9'($urandom % 32);
    meas.vsys <= 9'h168;
    wait_state(3'h2);
    check({31'h0, drive.fet_full}, 32'h1, "full fet");
    check({24'h0, drive.i_target}, 32'h32, "fast current");
    check({31'h0, line}, 32'h0, "pin low while charging");
    rd(lcs_pkg::OFS_STATUS, 32'h02, 32'h3f, 1'h0);
    repeat (40)
    begin
      meas.peak_over <= 1'($urandom % 2);
      @(posedge i_mclk);
    end
    meas.peak_over <= 1'h0;
    meas.die_hot <= 1'h1;
    k = 0;
    do
    begin
      @(posedge i_mclk);
      k++;
    end
    while (drive.i_target >= 8'h32 && k < 50);
    check({31'h0, drive.i_target < 8'h32}, 32'h1, "thermal cut");
    if (drive.i_target >= 8'h32)
    begin
      give_verdict();
    end
    rd(lcs_pkg::OFS_LOOPS, 32'h2, 32'hffffffff, 1'h0);
    meas.die_hot <= 1'h0;
    meas.vin_low <= 1'h1;
    repeat (3) @(posedge i_mclk);
    rd(lcs_pkg::OFS_LOOPS, 32'h4, 32'hffffffff, 1'h0);
    meas.vin_low <= 1'h0;
    wr(lcs_pkg::OFS_CTRL, 32'h04);
    rd(lcs_pkg::OFS_CTRL, 32'h04, 32'h1e, 1'h0);
    check({31'h0, line}, 32'h1, "pin off when disabled");
    wr(lcs_pkg::OFS_CTRL, 32'h10);
    $display("fast charge test done");
    meas.vbat <= 9'h19f;
    meas.ichg <= 8'h08;
    wait_state(3'h3);
    check({31'h0, drive.fet_full}, 32'h1, "rail kept on battery");
    repeat (30) rd(lcs_pkg::OFS_STATUS, 32'h3, 32'h7, 1'h0);
    wr(lcs_pkg::OFS_CTRL, 32'h14);
    wait_state(3'h4);
    check({31'h0, drive.detect_sink}, 32'h1, "detection sink on");
    wait_state(3'h5);
    check({31'h0, line}, 32'h1, "pin released when done");
    rd(lcs_pkg::OFS_STATUS, 32'h25, 32'h3f, 1'h0);
    meas.sys_over <= 1'h1;
    repeat (3) @(posedge i_mclk);
    check({31'h0, drive.supplement}, 32'h1, "supplement in done");
    meas.sys_over <= 1'h0;
    repeat (3) @(posedge i_mclk);
    meas.fault <= 1'h1;
    k = 0;
    while (line !== 1'h0 && k < 20)
    begin
      @(posedge i_mclk);
      k++;
    end
    if (line !== 1'h0)
    begin
      check(32'h0, 32'h1, "no fault pulse");
      give_verdict();
    end
    k = 0;
    while (line === 1'h0 && k < 4000)
    begin
      @(posedge i_mclk);
      k++;
    end
    check(k, lcs_pkg::FAULT_PULSE_CYC, "fault pulse length");
    if (k >= 4000)
    begin
      give_verdict();
    end
    meas.fault <= 1'h0;
    $display("termination test done");
    meas.vbat <= 9'h190;
    wait_state(3'h2);
    meas.input_ok <= 1'h0;
    wait_state(3'h0);
    check({31'h0, line}, 32'h1, "pin released when off");
    meas.input_ok <= 1'h1;
    wait_state(3'h2);
    wr(lcs_pkg::OFS_CTRL, 32'h16);
    wait_state(3'h0);
    wr(lcs_pkg::OFS_CTRL, 32'h14);
    wait_state(3'h2);
    wr(lcs_pkg::OFS_CTRL, 32'h1c);
    wait_state(3'h0);
    wr(lcs_pkg::OFS_CTRL, 32'h14);
    wait_state(3'h2);
    $display("restart test done");
    give_verdict();
  end
endmodule
`default_nettype wire
